/* src/tlic_pkg.sv */
package tlic_pkg;

    localparam int NUM_SRC = 22;
    localparam int IDX_W   = 5;
    localparam int ADR_W   = 8;

    // register byte addresses on the wishbone slave
    localparam logic [ADR_W-1:0] OFS_IRQ_EN    = 8'h00;
    localparam logic [ADR_W-1:0] OFS_EXT_EN_A  = 8'h04;
    localparam logic [ADR_W-1:0] OFS_EXT_EN_B  = 8'h08;
    localparam logic [ADR_W-1:0] OFS_IRQ_PRI   = 8'h0C;
    localparam logic [ADR_W-1:0] OFS_EXT_PRI_A = 8'h10;
    localparam logic [ADR_W-1:0] OFS_EXT_PRI_B = 8'h14;
    localparam logic [ADR_W-1:0] OFS_PENDING   = 8'h18;
    localparam logic [ADR_W-1:0] OFS_STATUS    = 8'h1C;

    // field layout
    localparam int GLOBAL_EN_BIT = 7;
    localparam int STD_SRC_CNT   = 7;
    localparam int EXT_A_CNT     = 8;
    localparam int EXT_B_CNT     = 7;
    localparam int STAT_ACT_LO   = 0;
    localparam int STAT_ACT_HI   = 1;
    localparam int STAT_HOLD     = 2;
    localparam int STAT_REQ      = 3;
    localparam int STAT_IDX_LSB  = 8;

    // reset values
    localparam logic [7:0]         EN_RESET      = 8'h00;
    localparam logic [7:0]         PRI_RESET     = 8'h00;
    localparam logic [NUM_SRC-1:0] PEND_RESET    = 22'h000000;
    localparam logic [NUM_SRC-1:0] HW_CLEAR_MASK = 22'h00000F;
    localparam logic [NUM_SRC-1:0] RESERVED_MASK = 22'h042000;

    // vector map
    localparam logic [15:0] VEC_BASE = 16'h0003;
    localparam logic [15:0] VEC_STEP = 16'h0008;

    // timing in system clock cycles
    localparam int DETECT_CYCLES = 1;
    localparam int CALL_CYCLES   = 5;
    localparam int FAST_RESPONSE = 7;

    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [ADR_W-1:0] adr;
        logic [3:0]       sel;
        logic [31:0]      dat;
    } tlic_wb_req_t;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } tlic_wb_rsp_t;

    typedef struct packed {
        logic             valid;
        logic             high;
        logic [IDX_W-1:0] idx;
        logic [15:0]      vector;
    } tlic_cpu_req_t;

    typedef struct packed {
        logic instr_done;
        logic accept;
        logic return_from_irq_instr_done;
    } tlic_cpu_evt_t;

endpackage

/* src/tlic_ctrl.sv */
`timescale 1ns/1ps
// Overview of operation
// - a source event sets its pending flag regardless of any enable
// - request only when pending, source enabled and global enable all set
// - CPU finishes current instruction, then calls the source's fixed vector
// - return instruction resumes the interrupted program at its next instruction
// - disabled sources are ignored and no vectoring happens
// - some flags auto-clear on vectoring, others stay until software clears
// - flag still set after return re-requests after one further instruction
// - per-source enables count only while global enable bit 7 is one
// - global enable zero blocks every source
// - events while globally disabled stay pending and are serviced later
// - one independent enable bit per source across standard and extended registers
// - software writing one to a flag acts like a hardware event
// - high level may preempt low; nothing preempts a high routine
// - preempted low routine resumes and finishes after the high routine returns
// - one priority bit per source, all defaulting to low
// - simultaneous requests: high level first, then fixed source order
// - requests sampled each cycle; fastest response is seven cycles
// - equal or higher routine running delays new requests past return plus one
// - source 0 vectors to 0x0003, each later source eight bytes higher
module tlic_ctrl
    import tlic_pkg::*;
#(
    parameter int                      SRC_CNT  = tlic_pkg::NUM_SRC,
    parameter logic [SRC_CNT-1:0]      AUTO_CLR = tlic_pkg::HW_CLEAR_MASK
) (
    // clock and reset
    input  wire logic                  CORE_CLK,
    input  wire logic                  RESET,
    // wishbone slave
    input  wire tlic_pkg::tlic_wb_req_t WB_REQ,
    output tlic_pkg::tlic_wb_rsp_t     WB_RSP,
    // peripheral interrupt events, one-cycle pulses on CORE_CLK
    input  wire logic [SRC_CNT-1:0]    SRC_EVENT,
    // cpu sequencer
    input  wire tlic_pkg::tlic_cpu_evt_t CPU_EVT,
    output tlic_pkg::tlic_cpu_req_t    CPU_REQ,
    output logic [SRC_CNT-1:0]         PENDING
);
    import tlic_pkg::*;

    logic [7:0]         irq_en_q;
    logic [7:0]         ext_en_a_q;
    logic [7:0]         ext_en_b_q;
    logic [7:0]         irq_pri_q;
    logic [7:0]         ext_pri_a_q;
    logic [7:0]         ext_pri_b_q;
    logic [SRC_CNT-1:0] pend_q;
    logic               act_lo_q;
    logic               act_hi_q;
    logic               hold_q;
    tlic_cpu_req_t      req_q;
    tlic_cpu_req_t      req_d;
    logic               ack_q;
    logic [31:0]        rdat_q;
    logic [31:0]        rdat_d;

    logic               global_irq_enable;
    logic [SRC_CNT-1:0] src_en;
    logic [SRC_CNT-1:0] src_hi;
    logic [SRC_CNT-1:0] cand;
    logic [SRC_CNT-1:0] cand_hi;
    logic [SRC_CNT-1:0] cand_lo;
    logic [SRC_CNT-1:0] sw_set;
    logic [SRC_CNT-1:0] sw_clr;
    logic [SRC_CNT-1:0] hw_clr;
    logic               wr_stb;
    logic               accept;

    // a slave that answers one cycle after the request and drops ack at once;
    // writes land on the edge where the master sees ack, never before it
    assign wr_stb = WB_REQ.cyc & WB_REQ.stb & WB_REQ.we & ack_q;
    assign accept = CPU_EVT.accept & req_q.valid;

    assign global_irq_enable = irq_en_q[GLOBAL_EN_BIT];
    // source order: standard bits 0..6, ext a bits 0..7, ext b bits 0..6
    assign src_en = {ext_en_b_q[EXT_B_CNT-1:0], ext_en_a_q, irq_en_q[STD_SRC_CNT-1:0]};
    assign src_hi = {ext_pri_b_q[EXT_B_CNT-1:0], ext_pri_a_q, irq_pri_q[STD_SRC_CNT-1:0]};

    // pending flags are kept while disabled so they fire once enabled again
    assign cand    = pend_q & src_en & ~RESERVED_MASK & {SRC_CNT{global_irq_enable}};
    assign cand_hi = cand & src_hi;
    assign cand_lo = cand & ~src_hi;

    function automatic logic [IDX_W-1:0] first_set(input logic [SRC_CNT-1:0] v);
        logic [IDX_W-1:0] r;
        r = '0;
        for (int i = SRC_CNT - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = IDX_W'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] vec_of(input logic [IDX_W-1:0] idx);
        logic [15:0] r;
        r = VEC_BASE + VEC_STEP * {11'h000, idx};
        return r;
    endfunction

    // arbitration, recomputed every cycle and registered once (detect cycle)
    always_comb begin
        req_d = '0;
        if (!hold_q) begin
            if (|cand_hi && !act_hi_q) begin
                req_d.valid  = 1'b1;
                req_d.high   = 1'b1;
                req_d.idx    = first_set(cand_hi);
            end else if (|cand_lo && !act_hi_q && !act_lo_q) begin
                req_d.valid  = 1'b1;
                req_d.high   = 1'b0;
                req_d.idx    = first_set(cand_lo);
            end
        end
        req_d.vector = vec_of(req_d.idx);
    end

    // request to the sequencer; dropped the cycle it is taken or when it lapses
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            req_q <= '0;
        end else if (accept) begin
            req_q <= '0;
        end else begin
            req_q <= req_d;
        end
    end

    // cpu takes the request at an instruction boundary and performs the call
    assign CPU_REQ = req_q;

    // in-service levels: a high call may nest over a low one
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            act_lo_q <= 1'b0;
            act_hi_q <= 1'b0;
        end else if (accept) begin
            if (req_q.high) begin
                act_hi_q <= 1'b1;
            end else begin
                act_lo_q <= 1'b1;
            end
        end else if (CPU_EVT.return_from_irq_instr_done) begin
            // innermost routine returns first; a preempted low one stays active
            if (act_hi_q) begin
                act_hi_q <= 1'b0;
            end else begin
                act_lo_q <= 1'b0;
            end
        end
    end

    // after a return one more instruction must run before any new call
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            hold_q <= 1'b0;
        end else if (CPU_EVT.return_from_irq_instr_done) begin
            hold_q <= 1'b1;
        end else if (CPU_EVT.instr_done) begin
            hold_q <= 1'b0;
        end
    end

    // software writes to the pending register
    always_comb begin
        sw_set = '0;
        sw_clr = '0;
        if (wr_stb && WB_REQ.adr == OFS_PENDING) begin
            for (int i = 0; i < SRC_CNT; i++) begin
                if (WB_REQ.sel[i / 8]) begin
                    sw_set[i] = WB_REQ.dat[i];
                    sw_clr[i] = ~WB_REQ.dat[i];
                end
            end
        end
    end

    // hardware clears only sources marked self-clearing, at the call
    always_comb begin
        hw_clr = '0;
        if (accept) begin
            hw_clr[req_q.idx] = AUTO_CLR[req_q.idx];
        end
    end

    // set beats clear so an event in the clearing cycle is not lost
    genvar g;
    generate
        for (g = 0; g < SRC_CNT; g++) begin : g_pend
            always_ff @(posedge CORE_CLK) begin
                if (RESET) begin
                    pend_q[g] <= PEND_RESET[g];
                end else if (SRC_EVENT[g] || sw_set[g]) begin
                    pend_q[g] <= 1'b1;
                end else if (sw_clr[g] || hw_clr[g]) begin
                    pend_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign PENDING = pend_q;

    // enable registers
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            irq_en_q   <= EN_RESET;
            ext_en_a_q <= EN_RESET;
            ext_en_b_q <= EN_RESET;
        end else if (wr_stb && WB_REQ.sel[0]) begin
            if (WB_REQ.adr == OFS_IRQ_EN) begin
                irq_en_q <= WB_REQ.dat[7:0];
            end else if (WB_REQ.adr == OFS_EXT_EN_A) begin
                ext_en_a_q <= WB_REQ.dat[7:0];
            end else if (WB_REQ.adr == OFS_EXT_EN_B) begin
                ext_en_b_q <= {1'b0, WB_REQ.dat[6:0]};
            end
        end
    end

    // priority registers; bit 7 of the standard one has no source
    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            irq_pri_q   <= PRI_RESET;
            ext_pri_a_q <= PRI_RESET;
            ext_pri_b_q <= PRI_RESET;
        end else if (wr_stb && WB_REQ.sel[0]) begin
            if (WB_REQ.adr == OFS_IRQ_PRI) begin
                irq_pri_q <= {1'b0, WB_REQ.dat[6:0]};
            end else if (WB_REQ.adr == OFS_EXT_PRI_A) begin
                ext_pri_a_q <= WB_REQ.dat[7:0];
            end else if (WB_REQ.adr == OFS_EXT_PRI_B) begin
                ext_pri_b_q <= {1'b0, WB_REQ.dat[6:0]};
            end
        end
    end

    // read mux; unmapped addresses read zero and are still acknowledged
    always_comb begin
        rdat_d = '0;
        if (WB_REQ.adr == OFS_IRQ_EN) begin
            rdat_d[7:0] = irq_en_q;
        end else if (WB_REQ.adr == OFS_EXT_EN_A) begin
            rdat_d[7:0] = ext_en_a_q;
        end else if (WB_REQ.adr == OFS_EXT_EN_B) begin
            rdat_d[7:0] = ext_en_b_q;
        end else if (WB_REQ.adr == OFS_IRQ_PRI) begin
            rdat_d[7:0] = irq_pri_q;
        end else if (WB_REQ.adr == OFS_EXT_PRI_A) begin
            rdat_d[7:0] = ext_pri_a_q;
        end else if (WB_REQ.adr == OFS_EXT_PRI_B) begin
            rdat_d[7:0] = ext_pri_b_q;
        end else if (WB_REQ.adr == OFS_PENDING) begin
            rdat_d[SRC_CNT-1:0] = pend_q;
        end else if (WB_REQ.adr == OFS_STATUS) begin
            rdat_d[STAT_ACT_LO] = act_lo_q;
            rdat_d[STAT_ACT_HI] = act_hi_q;
            rdat_d[STAT_HOLD]   = hold_q;
            rdat_d[STAT_REQ]    = req_q.valid;
            rdat_d[STAT_IDX_LSB +: IDX_W] = req_q.idx;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RESET) begin
            ack_q  <= 1'b0;
            rdat_q <= '0;
        end else begin
            ack_q  <= WB_REQ.cyc & WB_REQ.stb & ~ack_q;
            rdat_q <= (WB_REQ.cyc & WB_REQ.stb & ~WB_REQ.we & ~ack_q) ? rdat_d : 32'h00000000;
        end
    end

    assign WB_RSP.ack = ack_q;
    assign WB_RSP.dat = rdat_q;

endmodule

/* testbench/tlic_ctrl_properties.sv */
`timescale 1ns/1ps
module tlic_ctrl_chk
    import tlic_pkg::*;
#(
    parameter int                 SRC_CNT  = NUM_SRC,
    parameter logic [SRC_CNT-1:0] AUTO_CLR = HW_CLEAR_MASK
) (
    // clock and reset
    input wire logic                    CORE_CLK,
    input wire logic                    RESET,
    // watched ports
    input wire tlic_pkg::tlic_wb_req_t  WB_REQ,
    input wire tlic_pkg::tlic_wb_rsp_t  WB_RSP,
    input wire logic [SRC_CNT-1:0]      SRC_EVENT,
    input wire tlic_pkg::tlic_cpu_evt_t CPU_EVT,
    input wire tlic_pkg::tlic_cpu_req_t CPU_REQ,
    input wire logic [SRC_CNT-1:0]      PENDING
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RESET);
    logic [SRC_CNT-1:0] pend_q;
    wire                acc = CPU_EVT.accept & CPU_REQ.valid;
    // a bus write in the same edge may legally move a flag
    wire                wr = WB_REQ.cyc & WB_REQ.stb & WB_REQ.we;
    always_ff @(posedge CORE_CLK) pend_q <= PENDING;

    ack_one_a: assert property (WB_RSP.ack |=> !WB_RSP.ack)
        else $error("ack longer than one cycle");
    ack_late_a: assert property (WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack |=> WB_RSP.ack)
        else $error("bus answer late");
    pend_set_a:
        assert property (|SRC_EVENT |=> (PENDING & $past(SRC_EVENT)) == $past(SRC_EVENT))
        else $error("event did not set flag");
    req_pend_a:
        assert property (CPU_REQ.valid |-> PENDING[CPU_REQ.idx] || pend_q[CPU_REQ.idx])
        else $error("request without flag");
    vec_map_a:
        assert property (CPU_REQ.valid |-> CPU_REQ.vector == 16'h0003 + 16'h0008 * CPU_REQ.idx
            && CPU_REQ.idx != 5'h0D && CPU_REQ.idx != 5'h12)
        else $error("bad vector");
    drop_acc_a: assert property (acc |=> !CPU_REQ.valid)
        else $error("request held after accept");
    auto_clr_a:
        assert property (acc && AUTO_CLR[CPU_REQ.idx] && !SRC_EVENT[CPU_REQ.idx] && !wr
            |=> !PENDING[$past(CPU_REQ.idx)])
        else $error("flag not auto cleared");
    keep_flag_a:
        assert property (acc && !AUTO_CLR[CPU_REQ.idx] && !wr |=> PENDING[$past(CPU_REQ.idx)])
        else $error("flag lost on vectoring");
    ret_hold_a: assert property (CPU_EVT.return_from_irq_instr_done |=> !CPU_REQ.valid [*2])
        else $error("request right after return");
    rst_val_a:
        assert property (disable iff (1'b0) RESET |=> !WB_RSP.ack && CPU_REQ == '0
            && PENDING == '0)
        else $error("outputs not cleared by reset");

    cover property (acc && CPU_REQ.high);
    cover property (acc && !CPU_REQ.high);
    cover property (CPU_EVT.return_from_irq_instr_done);
    cover property (WB_RSP.ack && !WB_REQ.we);
endmodule

/* testbench/tlic_cpu_model.sv */
`timescale 1ns/1ps
module tlic_cpu_model
    import tlic_pkg::*;
(
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    rst,
    // request from the controller
    input  wire tlic_pkg::tlic_cpu_req_t req,
    // bench controls: stall delays the call, ret_cmd runs a return
    input  wire logic                    stall,
    input  wire logic                    ret_cmd,
    // events to the controller
    output tlic_pkg::tlic_cpu_evt_t      evt
);
    // an instruction ends every second cycle; a call starts only on that boundary
    always_ff @(posedge clk) begin
        if (rst) begin
            evt <= '0;
        end else begin
            evt.instr_done <= ~evt.instr_done & ~ret_cmd;
            evt.accept     <= req.valid & ~evt.accept & ~evt.instr_done & ~stall;
            evt.return_from_irq_instr_done  <= ret_cmd;
        end
    end
endmodule

/* testbench/tlic_ctrl_tb_top.sv */
`timescale 1ns/1ps
module tlic_ctrl_tb_top;
    import tlic_pkg::*;
    logic          clk       = 1'b0;
    logic          rst       = 1'b1;
    tlic_wb_req_t  wb_req    = '0;
    tlic_wb_rsp_t  wb_rsp;
    logic [21:0]   src_event = '0;
    tlic_cpu_evt_t cpu_evt;
    tlic_cpu_req_t cpu_req;
    logic [21:0]   pending;
    logic          stall     = 1'b0;
    logic          ret_cmd   = 1'b0;
    logic [31:0]   rd;
    int            n_fail    = 0;
    int            tests_run = 0;

    initial forever #25 clk = ~clk;

    tlic_ctrl u_tlic_ctrl (.CORE_CLK(clk), .RESET(rst), .WB_REQ(wb_req), .WB_RSP(wb_rsp),
        .SRC_EVENT(src_event), .CPU_EVT(cpu_evt), .CPU_REQ(cpu_req), .PENDING(pending));
    tlic_cpu_model u_tlic_cpu_model (.clk(clk), .rst(rst), .req(cpu_req), .stall(stall),
        .ret_cmd(ret_cmd), .evt(cpu_evt));

    task automatic close_out();
        if (n_fail == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(logic we, logic [7:0] adr, logic [31:0] dat);
        int n;
        n = 0;
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
        do begin
            @(posedge clk);
            n++;
        end while (wb_rsp.ack !== 1'b1 && n < 20);
        rd = wb_rsp.dat;
        wb_req <= '0;
        if (n >= 20) begin
            check("bus wait", 32'h0, 32'h1);
            close_out();
        end
        @(posedge clk);
    endtask

    // waits for a request, checks it, then lets the model take the call
    task automatic serve(logic [31:0] idx, logic hi);
        int n;
        n = 0;
        while (cpu_req.valid !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        check("req idx", 32'(cpu_req.idx), idx);
        check("req level", 32'(cpu_req.high), 32'(hi));
        check("vector", 32'(cpu_req.vector), 32'h3 + 32'h8 * idx);
        while (cpu_evt.accept !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        if (n >= 60) begin
            check("cpu wait", 32'h0, 32'h1);
            close_out();
        end
        @(posedge clk);
    endtask

    task automatic irq_return();
        ret_cmd <= 1'b1;
        @(posedge clk);
        ret_cmd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic quiet(int cyc);
        repeat (cyc) begin
            @(posedge clk);
            check("no request", 32'(cpu_req.valid), 32'h0);
        end
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 6; a++) begin
            bus(1'b0, 8'(4 * a), 32'h0);
            check("reset reg", rd, 32'h0);
            bus(1'b1, 8'(4 * a), 32'h25);
            bus(1'b0, 8'(4 * a), 32'h0);
            check("reg", rd, 32'h25);
            bus(1'b1, 8'(4 * a), 32'h0);
        end
        bus(1'b1, 8'h20, 32'hFF);
        bus(1'b0, 8'h20, 32'h0);
        check("unmapped", rd, 32'h0);
        bus(1'b1, OFS_IRQ_EN, 32'h01);
        src_event <= 22'h1;
        @(posedge clk);
        src_event <= '0;
        quiet(6);
        check("flag", 32'(pending[0]), 32'h1);
        stall <= 1'b1;
        bus(1'b1, OFS_IRQ_EN, 32'h81);
        @(posedge clk);
        check("detect", 32'(cpu_req.valid), 32'h1);
        repeat (5) @(posedge clk);
        check("req stands", 32'(cpu_req.valid), 32'h1);
        stall <= 1'b0;
        serve(32'h0, 1'b0);
        irq_return();
        bus(1'b1, OFS_PENDING, 32'h2);
        quiet(6);
        check("sw flag", 32'(pending[1]), 32'h1);
        // the ignored flag would fire as soon as everything is enabled below
        bus(1'b1, OFS_PENDING, 32'h0);
        bus(1'b1, OFS_EXT_EN_A, 32'hFF);
        bus(1'b1, OFS_EXT_EN_B, 32'hFF);
        bus(1'b1, OFS_IRQ_EN, 32'hFF);
        for (int i = 0; i < 22; i++) begin
            if (i == 13 || i == 18) continue;
            bus(1'b1, OFS_PENDING, 32'h1 << i);
            serve(32'(i), 1'b0);
            bus(1'b1, OFS_PENDING, 32'h0);
            irq_return();
        end
        bus(1'b1, OFS_PENDING, 32'h42000);
        quiet(6);
        bus(1'b1, OFS_PENDING, 32'h210);
        serve(32'h4, 1'b0);
        irq_return();
        serve(32'h4, 1'b0);
        bus(1'b1, OFS_PENDING, 32'h0);
        irq_return();
        bus(1'b1, OFS_IRQ_PRI, 32'h20);
        bus(1'b1, OFS_PENDING, 32'h24);
        serve(32'h5, 1'b1);
        bus(1'b1, OFS_PENDING, 32'h4);
        quiet(6);
        irq_return();
        serve(32'h2, 1'b0);
        bus(1'b1, OFS_PENDING, 32'h20);
        serve(32'h5, 1'b1);
        bus(1'b1, OFS_PENDING, 32'h0);
        irq_return();
        bus(1'b0, OFS_STATUS, 32'h0);
        check("low still active", 32'(rd[1:0]), 32'h1);
        irq_return();
        quiet(4);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        bus(1'b0, OFS_IRQ_PRI, 32'h0);
        check("prio after reset", rd, 32'h0);
        close_out();
    end
endmodule

bind tlic_ctrl tlic_ctrl_chk #(.SRC_CNT(SRC_CNT), .AUTO_CLR(AUTO_CLR)) u_tlic_ctrl_chk (
    .CORE_CLK(CORE_CLK), .RESET(RESET), .WB_REQ(WB_REQ), .WB_RSP(WB_RSP),
    .SRC_EVENT(SRC_EVENT), .CPU_EVT(CPU_EVT), .CPU_REQ(CPU_REQ), .PENDING(PENDING));
